/* File: bench/sbg_serial_partner.sv */
// Far-side model: transmitter busy status and receive line driver.
// Assumes bit_tick_i pulses once per bit period from the baud tick generator.
`timescale 1ns/1ns
module sbg_serial_partner (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic bit_tick_i,
  input  wire logic tx_start_i,
  input  wire logic line_level_i,
  output logic      shift_register_empty_o,
  output logic      receive_data_pin_o
);
  logic [3:0] bits_left_r;

  // A frame of ten bits keeps the shift register busy
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bits_left_r        <= 4'h0;
      receive_data_pin_o <= 1'b1;
    end else begin
      if (tx_start_i)
        bits_left_r <= 4'hA;
      else if (bit_tick_i && bits_left_r != 4'h0)
        bits_left_r <= bits_left_r - 4'h1;
      // The line changes only at bit boundaries
      if (bit_tick_i)
        receive_data_pin_o <= line_level_i;
    end
  end

  assign shift_register_empty_o = (bits_left_r == 4'h0);
endmodule : sbg_serial_partner

/* File: bench/sbg_top_tb_top.sv */
// Testbench for the serial baud tick generator: registers, tick periods, receive vote.
// Assumes the partner model drives transmitter status and the receive pin.
`timescale 1ns/1ns
module sbg_top_tb_top
  import sbg_pkg::*;
;
  logic        clk_sys_i  = 1'b0;
  logic        rst_i      = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  pstrb      = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sre;
  logic        rxpin;
  logic        baud;
  logic        bitclk;
  logic        lvl;
  logic        lvlv;
  logic [7:0]  xmt;
  logic [7:0]  rcv;
  logic        smp;
  logic        tx_start   = 1'b0;
  logic        line_level = 1'b1;
  int          cyc        = 0;
  int          errors     = 0;
  int          n_compared = 0;

  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  sbg_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .shift_register_empty_i(sre),
    .receive_data_pin_i(rxpin), .baud_tick_o(baud), .bit_clk_tick_o(bitclk), .sample_tick_o(smp),
    .rx_level_o(lvl), .rx_level_valid_o(lvlv), .receive_control_reg_o(rcv),
    .transmit_control_reg_o(xmt));

  sbg_serial_partner partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bit_tick_i(bitclk),
    .tx_start_i(tx_start), .line_level_i(line_level), .shift_register_empty_o(sre),
    .receive_data_pin_o(rxpin));

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwrite <= wr;
    // a is the register index; each register is one word
    paddr  <= {a[9:0], 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 8'h00, rd, e);
    chk(nm, exp, rd);
  endtask : rd_chk

  task automatic wait_flag(input bit use_lvl, output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while ((use_lvl ? lvlv : baud) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      errors++;
      end_of_test();
    end
    t = cyc;
  endtask : wait_flag

  // Two consecutive ticks give one bit period in clock cycles
  task automatic period(input logic [7:0] cfg, input logic [7:0] x);
    int t0;
    int t1;
    int e;
    wr(SBG_XMT_CTRL_OFFS, cfg);
    wr(SBG_DIVISOR_OFFS, x);
    wait_flag(1'b0, t0);
    wait_flag(1'b0, t1);
    e = cfg[SBG_BIT_SYNC_MODE] ? 4 : (cfg[SBG_BIT_HIGH_SPEED] ? 16 : 64);
    chk("period", e * (x + 1), t1 - t0);
  endtask : period

  task automatic count(output int nb, output int nc, output int ns);
    nb = 0;
    nc = 0;
    ns = 0;
    repeat (4) @(posedge clk_sys_i);
    repeat (40) begin
      @(posedge clk_sys_i);
      if (baud === 1'b1) nb++;
      if (bitclk === 1'b1) nc++;
      if (smp === 1'b1) ns++;
    end
  endtask : count

  initial begin
    int          t0;
    int          t1;
    int          ns;
    logic [31:0] rd;
    logic        e;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk("divisor_rst", SBG_DIVISOR_OFFS, 32'h00);
    rd_chk("xmt_rst", SBG_XMT_CTRL_OFFS, 32'h02);
    chk("xmt_port", 32'h02, {24'h0, xmt});
    rd_chk("rcv_rst", SBG_RCV_CTRL_OFFS, 32'h00);
    apb(1'b0, 12'h0FC, 8'h00, rd, e);
    chk("slverr", 32'h1, {31'h0, e});
    wr(SBG_XMT_CTRL_OFFS, 8'hFF);
    rd_chk("xmt_mask", SBG_XMT_CTRL_OFFS, 32'hF7);
    wr(SBG_RCV_CTRL_OFFS, 8'hFF);
    rd_chk("rcv_mask", SBG_RCV_CTRL_OFFS, 32'hF8);
    chk("rcv_port", 32'h000000F8, {24'h0, rcv});
    pstrb <= 4'h0;
    wr(SBG_XMT_CTRL_OFFS, 8'h00);
    pstrb <= 4'hF;
    tx_start <= 1'b1;
    @(posedge clk_sys_i);
    tx_start <= 1'b0;
    rd_chk("xmt_busy", SBG_XMT_CTRL_OFFS, 32'hF5);
    period(8'h00, 8'h00);
    period(8'h00, 8'h02);
    period(8'h04, 8'h00);
    period(8'h04, 8'h03);
    period(8'h90, 8'h00);
    period(8'h90, 8'hFF);
    period(8'h94, 8'h05);
    wr(SBG_XMT_CTRL_OFFS, 8'h10);
    wr(SBG_DIVISOR_OFFS, 8'h00);
    count(t0, t1, ns);
    chk("slave_bitclk", 32'h0, t1);
    chk("slave_baud", 32'h0000000A, t0);
    wr(SBG_XMT_CTRL_OFFS, 8'h90);
    count(t0, t1, ns);
    chk("master_bitclk", 32'h0000000A, t1);
    chk("master_baud", 32'h0000000A, t0);
    chk("sync_samples", 32'h0000000A, ns);
    wr(SBG_DIVISOR_OFFS, 8'hFF);
    repeat (100) @(posedge clk_sys_i);
    t0 = cyc;
    wr(SBG_DIVISOR_OFFS, 8'h00);
    wait_flag(1'b0, t1);
    chk("restart", 32'h1, {31'h0, (t1 - t0) < 16});
    wr(SBG_XMT_CTRL_OFFS, 8'h00);
    for (int i = 0; i < 2; i++) begin
      line_level <= i[0];
      repeat (200) @(posedge clk_sys_i);
      wait_flag(1'b1, t1);
      chk("rx_level", {31'h0, i[0]}, {31'h0, lvl});
    end
    end_of_test();
  end
endmodule : sbg_top_tb_top

/* File: src/sbg_majority.sv */
// Three-sample majority detector for the receive data pin.
// Assumes the pin is synchronous to the clock and sample_i pulses three times per async bit, once per sync bit;
// restart_i realigns the sample group with a restarted bit timer.
`timescale 1ns/1ns
module sbg_majority
  import sbg_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  input  wire logic sample_i,
  input  wire logic receive_data_pin_i,
  output logic      level_o,
  output logic      level_valid_o
);
  typedef struct packed {
    logic [2:0] samples;
    logic [1:0] idx;
    logic       level;
    logic       valid;
  } sbg_maj_state_type;

  sbg_maj_state_type state_r;
  sbg_maj_state_type state_nxt;

  function automatic logic vote3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  always_comb begin
    state_nxt       = state_r;
    state_nxt.valid = 1'b0;
    if (restart_i) begin
      state_nxt.idx = 2'h0;
    end else if (sample_i) begin
      state_nxt.samples = {state_r.samples[1:0], receive_data_pin_i};
      if (state_r.idx == SBG_VOTES_LAST) begin
        state_nxt.idx   = 2'h0;
        state_nxt.level = vote3({state_r.samples[1:0], receive_data_pin_i}); // see R10
        state_nxt.valid = 1'b1;
      end else begin
        state_nxt.idx = state_r.idx + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= '{samples: 3'h7, idx: 2'h0, level: 1'b1, valid: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign level_o       = state_r.level;
  assign level_valid_o = state_r.valid;

endmodule : sbg_majority

/* File: src/sbg_pkg.sv */
// Package for the serial baud tick generator: register map, field positions, reset values, divide ratios.
// Assumes a 32-bit APB slave; each register takes one word, byte address is four times its index.
package sbg_pkg;

  // Register indices, not byte addresses
  localparam logic [11:0] SBG_RCV_CTRL_OFFS  = 12'h018;
  localparam logic [11:0] SBG_XMT_CTRL_OFFS  = 12'h098;
  localparam logic [11:0] SBG_DIVISOR_OFFS   = 12'h099;
  localparam logic [11:0] SBG_STATUS_OFFS    = 12'h0A0;

  localparam logic [7:0]  SBG_RCV_CTRL_RST   = 8'h00;
  localparam logic [7:0]  SBG_XMT_CTRL_RST   = 8'h02;
  localparam logic [7:0]  SBG_DIVISOR_RST    = 8'h00;

  // Transmit control fields
  localparam int          SBG_BIT_CLK_MASTER = 7;
  localparam int          SBG_BIT_SYNC_MODE  = 4;
  localparam int          SBG_BIT_UNIMPL     = 3;
  localparam int          SBG_BIT_HIGH_SPEED = 2;
  localparam int          SBG_BIT_SHIFT_EMPT = 1;
  localparam logic [7:0]  SBG_XMT_WR_MASK    = 8'hF5;
  localparam logic [7:0]  SBG_RCV_WR_MASK    = 8'hF8;

  // Prescale of the oscillator and the async post-divider ratios
  localparam int          SBG_OSC_PRESCALE   = 4;
  localparam logic [3:0]  SBG_POST_LOW_LAST  = 4'hF;
  localparam logic [3:0]  SBG_POST_HIGH_LAST = 4'h3;
  localparam logic [1:0]  SBG_VOTES_LAST     = 2'h2;

  typedef struct packed {
    logic       sync_mode;
    logic       high_speed_select;
    logic       clock_source_master;
  } sbg_mode_type;

  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sbg_apb_req_type;

endpackage : sbg_pkg

/* File: src/sbg_prescale.sv */
// Oscillator prescaler: one-cycle tick every PRESCALE clocks.
// Assumes one free-running system clock; restart_i realigns the phase.
`timescale 1ns/1ns
module sbg_prescale
  import sbg_pkg::*;
#(
  parameter int PRESCALE = SBG_OSC_PRESCALE
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
    $error("sbg_prescale: bad PRESCALE");
  end

  typedef struct packed {
    logic [7:0] cnt;
  } sbg_pre_state_type;

  sbg_pre_state_type state_r;
  sbg_pre_state_type state_nxt;

  localparam logic [7:0] LAST = 8'(PRESCALE - 1);

  always_comb begin
    state_nxt = state_r;
    if (restart_i || state_r.cnt == LAST) begin
      state_nxt.cnt = 8'h00;
    end else begin
      state_nxt.cnt = state_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick_o = !restart_i && (state_r.cnt == LAST);

endmodule : sbg_prescale

/* File: src/sbg_top.sv */
// Serial baud tick generator with APB register access and receive-pin majority detector.
// Assumes clk_sys_i is the oscillator clock, a synchronous APB master, and a synchronous receive pin.
// Function
// R1 - Dedicated 8-bit reloading timer sets bit rate
// R2 - High-speed bit selects async divide ratio
// R3 - Synchronous mode ignores high-speed bit
// R4 - Async low speed: osc / (64*(X+1))
// R5 - Async high speed: osc / (16*(X+1))
// R6 - Synchronous: osc / (4*(X+1))
// R7 - Rate drives bit clock only as master; code also drives it in async mode whatever the clock source bit
// R8 - Divisor uses full 0 to 255 range
// R9 - Divisor write restarts the rate timer
// R10 - Receive pin majority of three samples
// R11 - Divisor clears to zero on reset
// R12 - Transmit control resets to shift-empty only
// R13 - Mode bit set means synchronous operation
// R14 - Clock source bit set means sync master
// R15 - Prescale by four, reload, post-divide async
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module sbg_top
  import sbg_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        shift_register_empty_i,
  input  wire logic        receive_data_pin_i,
  output logic             baud_tick_o,
  output logic             bit_clk_tick_o,
  output logic             sample_tick_o,
  output logic             rx_level_o,
  output logic             rx_level_valid_o,
  output logic [7:0]       receive_control_reg_o,
  output logic [7:0]       transmit_control_reg_o
);

  typedef struct packed {
    logic [7:0]  transmit_control_reg;
    logic [7:0]  receive_control_reg;
    logic [7:0]  baud_divisor_reg;
    logic [7:0]  timer;
    logic [3:0]  post;
    logic        baud_tick;
    logic        bit_clk_tick;
    logic        sample_tick;
    logic [31:0] prdata;
    logic        pslverr;
  } sbg_state_type;

  sbg_state_type state_r;
  sbg_state_type state_nxt;
  sbg_mode_type  mode;
  sbg_apb_req_type req;

  logic osc_tick;
  logic div_write;
  logic acc;
  logic timer_wrap;
  logic post_wrap;
  logic [3:0] post_last;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
    return a == {offs[9:0], 2'b00};
  endfunction : hit

  assign req       = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};
  assign acc       = req.sel && req.enable;
  assign div_write = acc && req.write && hit(req.addr, SBG_DIVISOR_OFFS) && pstrb_i[0];

  assign mode.sync_mode           = state_r.transmit_control_reg[SBG_BIT_SYNC_MODE];   // see R13
  assign mode.high_speed_select   = state_r.transmit_control_reg[SBG_BIT_HIGH_SPEED];
  assign mode.clock_source_master = state_r.transmit_control_reg[SBG_BIT_CLK_MASTER];

  sbg_prescale #(
    .PRESCALE (SBG_OSC_PRESCALE)                                                        // see R15
  ) u_prescale (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .restart_i (div_write),
    .tick_o    (osc_tick)
  );

  // Async post-divider length; sync mode bypasses it
  assign post_last  = mode.high_speed_select ? SBG_POST_HIGH_LAST : SBG_POST_LOW_LAST; // see R2
  assign timer_wrap = osc_tick && (state_r.timer == 8'h00);                             // see R1
  assign post_wrap  = timer_wrap && (mode.sync_mode || state_r.post == post_last);      // see R3

  always_comb begin
    state_nxt              = state_r;
    state_nxt.baud_tick    = 1'b0;
    state_nxt.bit_clk_tick = 1'b0;
    state_nxt.sample_tick  = 1'b0;
    state_nxt.pslverr      = 1'b0;

    // Timer counts prescaled ticks down and reloads from the divisor
    if (div_write) begin
      state_nxt.timer = pwdata_i[7:0];                                                  // see R9
      state_nxt.post  = 4'h0;
    end else if (osc_tick) begin
      if (state_r.timer == 8'h00) begin
        state_nxt.timer = state_r.baud_divisor_reg;                                     // see R8
      end else begin
        state_nxt.timer = state_r.timer - 8'h01;
      end
    end

    if (timer_wrap && !div_write) begin
      if (post_wrap) begin
        state_nxt.post      = 4'h0;
        state_nxt.baud_tick = 1'b1;                                                     // see R4
      end else begin
        state_nxt.post = state_r.post + 4'h1;                                           // see R5
      end
      // Three majority samples around mid-bit of the async post-divider
      if (!mode.sync_mode && (state_r.post == (post_last >> 1) - 4'h1 ||
          state_r.post == (post_last >> 1) || state_r.post == (post_last >> 1) + 4'h1)) begin
        state_nxt.sample_tick = 1'b1;                                                   // see R10
      end
    end
    if (mode.sync_mode && timer_wrap && !div_write) begin
      state_nxt.sample_tick = 1'b1;                                                     // see R6
    end
    // Bit clock follows the generator except in synchronous slave mode
    state_nxt.bit_clk_tick = state_nxt.baud_tick &&
                             (!mode.sync_mode || mode.clock_source_master);             // see R7 R14

    // APB access
    if (req.sel && !req.enable && !req.write) begin
      if (hit(req.addr, SBG_RCV_CTRL_OFFS)) begin
        state_nxt.prdata = {24'h000000, state_r.receive_control_reg};
      end else if (hit(req.addr, SBG_XMT_CTRL_OFFS)) begin
        state_nxt.prdata = {24'h000000, state_r.transmit_control_reg};
      end else if (hit(req.addr, SBG_DIVISOR_OFFS)) begin
        state_nxt.prdata = {24'h000000, state_r.baud_divisor_reg};
      end else if (hit(req.addr, SBG_STATUS_OFFS)) begin
        state_nxt.prdata = {24'h000000, state_r.timer};
      end else begin
        state_nxt.prdata = 32'h00000000;
      end
    end
    if (acc) begin
      if (!(hit(req.addr, SBG_RCV_CTRL_OFFS) || hit(req.addr, SBG_XMT_CTRL_OFFS) ||
            hit(req.addr, SBG_DIVISOR_OFFS) || hit(req.addr, SBG_STATUS_OFFS))) begin
        state_nxt.pslverr = 1'b1;
      end else if (req.write && pstrb_i[0]) begin
        if (hit(req.addr, SBG_RCV_CTRL_OFFS)) begin
          state_nxt.receive_control_reg = (req.wdata[7:0] & SBG_RCV_WR_MASK) |
                                          (state_r.receive_control_reg & ~SBG_RCV_WR_MASK);
        end else if (hit(req.addr, SBG_XMT_CTRL_OFFS)) begin
          state_nxt.transmit_control_reg = (req.wdata[7:0] & SBG_XMT_WR_MASK) |
                                           (state_r.transmit_control_reg & ~SBG_XMT_WR_MASK);
        end else if (hit(req.addr, SBG_DIVISOR_OFFS)) begin
          state_nxt.baud_divisor_reg = req.wdata[7:0];                                  // see R8
        end
      end
    end
    // Shift-empty status tracks the transmitter; unimplemented bit stays zero
    state_nxt.transmit_control_reg[SBG_BIT_SHIFT_EMPT] = shift_register_empty_i;
    state_nxt.transmit_control_reg[SBG_BIT_UNIMPL]     = 1'b0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r                      <= '0;
      state_r.transmit_control_reg <= SBG_XMT_CTRL_RST;                                 // see R12
      state_r.receive_control_reg  <= SBG_RCV_CTRL_RST;
      state_r.baud_divisor_reg     <= SBG_DIVISOR_RST;                                  // see R11
    end else begin
      state_r <= state_nxt;
    end
  end

  sbg_majority u_majority (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .restart_i          (div_write),
    .sample_i           (state_r.sample_tick),
    .receive_data_pin_i (receive_data_pin_i),
    .level_o            (rx_level_o),
    .level_valid_o      (rx_level_valid_o)
  );

  assign prdata_o               = state_r.prdata;
  assign pready_o               = 1'b1;
  assign pslverr_o              = acc && !(hit(req.addr, SBG_RCV_CTRL_OFFS) || hit(req.addr, SBG_XMT_CTRL_OFFS) ||
                                           hit(req.addr, SBG_DIVISOR_OFFS) || hit(req.addr, SBG_STATUS_OFFS));
  assign baud_tick_o            = state_r.baud_tick;
  assign bit_clk_tick_o         = state_r.bit_clk_tick;
  assign sample_tick_o          = state_r.sample_tick;
  assign receive_control_reg_o  = state_r.receive_control_reg;
  assign transmit_control_reg_o = state_r.transmit_control_reg;

  // Checks
  sequence s_div_write;
    psel_i && penable_i && pwrite_i && hit(paddr_i, SBG_DIVISOR_OFFS) && pstrb_i[0];
  endsequence

  chk_div_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R11
    $rose(!rst_i) |-> state_r.baud_divisor_reg == 8'h00) else $error("divisor not zero after reset");
  chk_div_store: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R8
    s_div_write |=> state_r.baud_divisor_reg == $past(pwdata_i[7:0])) else $error("divisor write lost");
  chk_timer_restart: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R9
    s_div_write |=> state_r.timer == $past(pwdata_i[7:0]) && state_r.post == 4'h0) else $error("timer not restarted");
  chk_sync_ratio: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R6
    (mode.sync_mode && timer_wrap && !div_write) |=> baud_tick_o) else $error("sync tick missing");
  chk_async_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R4
    (!mode.sync_mode && timer_wrap && state_r.post != post_last) |=> !baud_tick_o) else $error("early async tick");
  chk_high_speed: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R5
    (!mode.sync_mode && mode.high_speed_select && timer_wrap && !div_write && state_r.post == SBG_POST_HIGH_LAST)
    |=> baud_tick_o) else $error("high speed ratio wrong");
  chk_slave_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R7
    (mode.sync_mode && !mode.clock_source_master) [*2] |-> !bit_clk_tick_o) else $error("slave bit clock driven");
  chk_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see R12
    !transmit_control_reg_o[SBG_BIT_UNIMPL]) else $error("unimplemented bit set");

endmodule : sbg_top
